// File: pmc_config.sv
`timescale 1ns/100ps
module pmc_config #(
   parameter int MEM_DEPTH = pmc_pkg::MEM_DEPTH_DEF
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_req,
   input  wire logic        i_write,
   input  wire logic [4:0]  i_port,
   input  wire logic [4:0]  i_reg,
   input  wire logic [15:0] i_wdata,
   output logic             o_ack,
   output logic [15:0]      o_rdata,
   input  wire logic        i_autoneg_enable_strap,
   input  wire logic [1:0]  i_speed_strap,
   input  wire logic        i_duplex_strap,
   input  wire logic        i_multinode_strap,
   input  wire logic [4:0]  i_port_addr_strap,
   input  wire logic        i_partner_manual,
   input  wire logic        i_partner_master,
   output logic             o_autoneg_en,
   output logic [1:0]       o_speed,
   output logic             o_full_duplex,
   output logic             o_power_down,
   output logic             o_master,
   output logic             o_use_local_clock,
   output logic             o_ms_fault,
   output logic             o_link_allowed
);
   import pmc_pkg::*;

   // refuse depths that the sixteen-bit pointer cannot address
   if (MEM_DEPTH < 2 || MEM_DEPTH > 65536) begin : g_depth_check
      $error("MEM_DEPTH out of range");
   end

   localparam int AW = $clog2(MEM_DEPTH);

   // -----------------------------------------
   // registers
   // -----------------------------------------
   logic [15:0] basic_reg;
   logic [15:0] gig_ctrl_reg;
   logic [15:0] access_reg;
   logic [15:0] ptr_reg;
   logic [4:0]  port_reg;
   logic        captured_reg;
   logic [7:0]  mem [MEM_DEPTH];

   // -----------------------------------------
   // decode
   // -----------------------------------------
   // port match
   wire         hit       = i_req && captured_reg && (i_port == port_reg);
   wire         wr        = hit && i_write;
   wire         rd        = hit && !i_write;
   wire         data_acc  = hit && (i_reg == ADDR_IND_DATA);
   wire         ptr_wr    = wr && (i_reg == ADDR_IND_PTR);
   wire         mode16    = access_reg[AC_WIDTH16];
   wire         autoinc   = access_reg[AC_AUTOINC];
   wire         wr_only   = access_reg[AC_WRITE_ONLY];
   // full pointer, only low bits index storage
   wire [AW-1:0] idx0     = ptr_reg[AW-1:0];
   wire [AW-1:0] idx1     = AW'(ptr_reg + 16'h0001);
   // 17-bit compare keeps a depth of 65536 and a pointer of 0xFFFF exact
   wire         in_range  = {1'b0, ptr_reg} < 17'(MEM_DEPTH);
   wire         in_range1 = ({1'b0, ptr_reg} + 17'h0_0001) < 17'(MEM_DEPTH);
   // step of one
   // 16-bit mode steps by one too, so back-to-back words overlap a byte
   wire [15:0]  ptr_inc   = ptr_reg + 16'h0001;

   function automatic logic [7:0] byte_or_zero(input logic [7:0] b, input logic ok);
      byte_or_zero = ok ? b : 8'h00;
   endfunction : byte_or_zero

   // read path, low byte in 8-bit mode
   // read in a process: a function reading the array hides it from sensitivity
   logic [15:0] mem_rdata;
   always_comb begin
      mem_rdata = {8'h00, byte_or_zero(mem[idx0], in_range)};
      if (mode16) begin
         mem_rdata[15:8] = byte_or_zero(mem[idx1], in_range1);
      end
   end
   wire [15:0]  gig_stat  = {o_ms_fault, 15'h0000};

   logic [15:0] rsel;
   always_comb begin
      case (i_reg)
         ADDR_BASIC_CTRL:  rsel = basic_reg;
         ADDR_GIG_CTRL:    rsel = gig_ctrl_reg;
         ADDR_GIG_STAT:    rsel = gig_stat;
         ADDR_ACCESS_CTRL: rsel = access_reg;
         // write-only mode returns zero on data reads
         ADDR_IND_DATA:    rsel = wr_only ? 16'h0000 : mem_rdata;
         ADDR_IND_PTR:     rsel = ptr_reg;
         ADDR_PORT_ADDR:   rsel = {11'h000, port_reg};
         default:          rsel = 16'h0000;
      endcase
   end

   // -----------------------------------------
   // register writes
   // -----------------------------------------
   // straps taken on first clock after reset release
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         captured_reg <= 1'b0;
         basic_reg    <= 16'h0000;
         gig_ctrl_reg <= 16'h0000;
         port_reg     <= 5'h00;
      end else if (!captured_reg) begin
         captured_reg <= 1'b1;
         basic_reg    <= 16'h0000;
         basic_reg[BC_AUTONEG_ENABLE_STRAP]     <= i_autoneg_enable_strap;
         basic_reg[BC_SPEED_LSB] <= i_speed_strap[0];
         basic_reg[BC_SPEED_MSB] <= i_speed_strap[1];
         basic_reg[BC_DUPLEX]    <= i_duplex_strap;
         gig_ctrl_reg <= 16'h0000;
         gig_ctrl_reg[GC_MS_MASTER] <= i_multinode_strap;
         port_reg     <= i_port_addr_strap;
      end else if (wr) begin
         case (i_reg)
            ADDR_BASIC_CTRL: basic_reg    <= i_wdata;
            ADDR_GIG_CTRL:   gig_ctrl_reg <= i_wdata;
            ADDR_PORT_ADDR:  port_reg     <= i_wdata[4:0];
            default:         ;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         access_reg <= ACCESS_CTRL_RST;
      end else if (wr && i_reg == ADDR_ACCESS_CTRL) begin
         access_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ptr_reg <= PTR_RST;
      end else if (ptr_wr) begin
         ptr_reg <= i_wdata;
      end else if (data_acc && autoinc) begin
         ptr_reg <= ptr_inc;
      end
   end

   always_ff @(posedge i_clock) begin
      if (data_acc && i_write && in_range) begin
         mem[idx0] <= i_wdata[7:0];
      end
      if (data_acc && i_write && mode16 && in_range1) begin
         mem[idx1] <= i_wdata[15:8];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_ack   <= 1'b0;
         o_rdata <= 16'h0000;
      end else begin
         o_ack   <= hit;
         o_rdata <= rd ? rsel : 16'h0000;
      end
   end

   // -----------------------------------------
   // mode resolution
   // -----------------------------------------
   wire         role_master = gig_ctrl_reg[GC_MS_MASTER];
   // same manual role at both ends
   wire         fault_next  = !o_autoneg_en && i_partner_manual && (i_partner_master == role_master);
   wire         speed_ok    = o_speed != SPD_RSVD;

   always_comb begin
      o_autoneg_en  = basic_reg[BC_AUTONEG_ENABLE_STRAP];
      o_speed       = {basic_reg[BC_SPEED_MSB], basic_reg[BC_SPEED_LSB]};
      o_full_duplex = basic_reg[BC_DUPLEX];
      o_power_down  = basic_reg[BC_POWER_DOWN];
      o_master      = role_master;
      o_ms_fault    = fault_next;
      o_use_local_clock = role_master;
      // manual gigabit relies on same-family partner
      o_link_allowed = captured_reg && !o_power_down &&
                       (o_autoneg_en || (speed_ok && !fault_next));
   end

   // -----------------------------------------
   // checks
   // -----------------------------------------
   sequence ptr_access_s;
      data_acc && autoinc && !ptr_wr;
   endsequence

   sequence byte_store_s;
      data_acc && i_write && !mode16 && in_range;
   endsequence

   sequence data_fetch_s;
      rd && (i_reg == ADDR_IND_DATA) && !wr_only && in_range;
   endsequence

   // sampled reset keeps the release edge itself out of the capture check
   sequence strap_edge_s;
      !captured_reg && !i_rst;
   endsequence

   ptr_incr_a: assert property (@(posedge i_clock) disable iff (i_rst)
      ptr_access_s |=> ptr_reg == $past(ptr_reg) + 16'h0001)
      else $error("pointer did not advance");

   ptr_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (captured_reg && !ptr_wr && !(data_acc && autoinc)) |=> $stable(ptr_reg))
      else $error("pointer moved without cause");

   ptr_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
      ptr_wr |=> ptr_reg == $past(i_wdata))
      else $error("pointer not loaded in full");

   port_match_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_req && i_port != port_reg) |=> !o_ack)
      else $error("ack on foreign port");

   foreign_wr_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_req && i_port != port_reg && i_reg == ADDR_ACCESS_CTRL) |=> $stable(access_reg))
      else $error("foreign write took effect");

   reserved_zero_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (rd && i_reg == ADDR_PORT_ADDR) |=> o_rdata[15:5] == 11'h000)
      else $error("reserved bits not zero");

   byte_store_a: assert property (@(posedge i_clock) disable iff (i_rst)
      byte_store_s |=> mem[$past(idx0)] == $past(i_wdata[7:0]))
      else $error("data byte not stored");

   byte_fetch_a: assert property (@(posedge i_clock) disable iff (i_rst)
      data_fetch_s |=> o_rdata[7:0] == $past(mem[idx0]))
      else $error("data byte not returned");

   byte_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (rd && i_reg == ADDR_IND_DATA && !mode16) |=> o_rdata[15:8] == 8'h00)
      else $error("high byte set in 8-bit mode");

   write_only_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (rd && i_reg == ADDR_IND_DATA && wr_only) |=> o_rdata == 16'h0000)
      else $error("data returned in write-only mode");

   zero_mode_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr && i_reg == ADDR_ACCESS_CTRL && i_wdata == 16'h0000) |=> !mode16 && !wr_only)
      else $error("zero access control not 8-bit read/write");

   an_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr && i_reg == ADDR_BASIC_CTRL && !i_wdata[BC_AUTONEG_ENABLE_STRAP]) |=> !o_autoneg_en)
      else $error("autoneg not disabled");

   ms_fault_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_ms_fault |-> !o_link_allowed)
      else $error("link allowed with role fault");

   role_link_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (captured_reg && !o_power_down && !i_partner_manual && speed_ok) |-> o_link_allowed)
      else $error("no link against negotiating partner");

   role_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr && i_reg == ADDR_GIG_CTRL) |=> o_master == $past(i_wdata[GC_MS_MASTER]))
      else $error("role not overridden");

   rsvd_speed_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (!o_autoneg_en && o_speed == SPD_RSVD) |-> !o_link_allowed)
      else $error("link with reserved speed");

   clock_src_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_use_local_clock == o_master)
      else $error("clock source mismatch");

   strap_take_a: assert property (@(posedge i_clock) disable iff (i_rst)
      strap_edge_s |=> o_autoneg_en == $past(i_autoneg_enable_strap) &&
                       o_speed == $past(i_speed_strap))
      else $error("straps not captured");

   strap_role_a: assert property (@(posedge i_clock) disable iff (i_rst)
      strap_edge_s |=> o_master == $past(i_multinode_strap) &&
                       o_full_duplex == $past(i_duplex_strap))
      else $error("role strap not captured");

   strap_over_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr && i_reg == ADDR_BASIC_CTRL) |=> o_full_duplex == $past(i_wdata[BC_DUPLEX]) &&
                                           o_speed[0] == $past(i_wdata[BC_SPEED_LSB]))
      else $error("control write did not replace strap value");
endmodule : pmc_config

// File: pmc_pkg.sv
package pmc_pkg;
   // register addresses on the management port
   localparam logic [4:0]  ADDR_BASIC_CTRL   = 5'h00;
   localparam logic [4:0]  ADDR_GIG_CTRL     = 5'h09;
   localparam logic [4:0]  ADDR_GIG_STAT     = 5'h0A;
   localparam logic [4:0]  ADDR_ACCESS_CTRL  = 5'h16;
   localparam logic [4:0]  ADDR_IND_DATA     = 5'h1D;
   localparam logic [4:0]  ADDR_IND_PTR      = 5'h1E;
   localparam logic [4:0]  ADDR_PORT_ADDR    = 5'h1F;
   // basic control fields
   localparam int          BC_SPEED_LSB      = 13;
   localparam int          BC_AUTONEG_ENABLE_STRAP          = 12;
   localparam int          BC_POWER_DOWN     = 11;
   localparam int          BC_DUPLEX         = 8;
   localparam int          BC_SPEED_MSB      = 6;
   // gigabit control fields: manual enable and master value; gigabit status fault bit
   localparam int          GC_MS_MANUAL      = 12;
   localparam int          GC_MS_MASTER      = 11;
   localparam int          GS_MS_FAULT       = 15;
   // access control fields
   localparam int          AC_WIDTH16        = 0;
   localparam int          AC_AUTOINC        = 1;
   localparam int          AC_WRITE_ONLY     = 2;
   localparam logic [15:0] ACCESS_CTRL_RST   = 16'h0000;
   localparam logic [15:0] PTR_RST           = 16'h0000;
   localparam logic [15:0] PORT_ADDR_MASK    = 16'h001F;
   localparam int          MEM_DEPTH_DEF     = 512;
   // speed codes
   localparam logic [1:0]  SPD_10            = 2'h0;
   localparam logic [1:0]  SPD_100           = 2'h1;
   localparam logic [1:0]  SPD_1000          = 2'h2;
   localparam logic [1:0]  SPD_RSVD          = 2'h3;
endpackage : pmc_pkg

// File: pmc_station.sv
`timescale 1ns/100ps
// ----------------------------------------
// management station model
// ----------------------------------------
module pmc_station (
   input  wire logic        i_clock,
   input  wire logic        i_ack,
   input  wire logic [15:0] i_rdata,
   output logic             o_req,
   output logic             o_write,
   output logic [4:0]       o_port,
   output logic [4:0]       o_reg,
   output logic [15:0]      o_wdata
);
   initial begin
      o_req   = 1'b0;
      o_write = 1'b0;
      o_port  = 5'h00;
      o_reg   = 5'h00;
      o_wdata = 16'h0000;
   end

   // one-cycle request, answer sampled just after the taking edge
   task automatic access(input logic wr, input logic [4:0] port, input logic [4:0] addr,
                         input logic [15:0] data, output logic [15:0] rd, output logic ack);
      @(posedge i_clock);
      o_req   <= 1'b1;
      o_write <= wr;
      o_port  <= port;
      o_reg   <= addr;
      o_wdata <= data;
      @(posedge i_clock);
      o_req   <= 1'b0;
      // released data inverted so a stale value can never pass
      o_wdata <= ~data;
      o_port  <= ~port;
      #1;
      rd  = i_rdata;
      ack = i_ack;
   endtask : access
endmodule : pmc_station

// File: tb.sv
`timescale 1ns/100ps
module tb;
   import pmc_pkg::*;
   localparam logic [4:0] PORT = 5'h05;
   logic i_clock, i_rst, req, wrt, ack, an_s, dup_s, multi_s, p_man, p_mst;
   logic [4:0] port, rg;
   logic [15:0] wdata, rdata;
   logic [1:0] spd_s, sp;
   logic an_o, fd_o, pd_o, ms_o, lc_o, flt_o, lnk_o, f;
   logic [1:0] spd_o;
   int err_count, total_checks;

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   pmc_station i_sta (.i_clock(i_clock), .i_ack(ack), .i_rdata(rdata), .o_req(req),
                      .o_write(wrt), .o_port(port), .o_reg(rg), .o_wdata(wdata));

   pmc_config i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_req(req), .i_write(wrt),
      .i_port(port), .i_reg(rg), .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata),
      .i_autoneg_enable_strap(an_s), .i_speed_strap(spd_s), .i_duplex_strap(dup_s),
      .i_multinode_strap(multi_s), .i_port_addr_strap(PORT), .i_partner_manual(p_man),
      .i_partner_master(p_mst), .o_autoneg_en(an_o), .o_speed(spd_o),
      .o_full_duplex(fd_o), .o_power_down(pd_o), .o_master(ms_o),
      .o_use_local_clock(lc_o), .o_ms_fault(flt_o), .o_link_allowed(lnk_o));

   // ----------------------------------------
   // compare and access tasks
   // ----------------------------------------
   task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_reg

   task automatic chk_out(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_out

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] r;
      logic        k;
      i_sta.access(1'b1, PORT, a, d, r, k);
      chk_out("write ack", 1'b1, k);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] r;
      logic        k;
      i_sta.access(1'b0, PORT, a, 16'h0000, r, k);
      chk_out("read ack", 1'b1, k);
      chk_reg($sformatf("reg %h", a), e, r);
   endtask : rd

   task automatic tally_and_finish();
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (5000) @(posedge i_clock);
      err_count++;
      tally_and_finish();
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      logic [15:0] r;
      logic        k;
      an_s = 1'b0; spd_s = SPD_100; dup_s = 1'b1; multi_s = 1'b1;
      p_man = 1'b0; p_mst = 1'b0; i_rst = 1'b1;
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      rd(ADDR_BASIC_CTRL, 16'h2100);
      chk_out("autoneg", 1'b0, an_o);
      chk_reg("speed", {14'h0000, SPD_100}, {14'h0000, spd_o});
      chk_out("duplex", 1'b1, fd_o);
      chk_out("master", 1'b1, ms_o);
      chk_out("local clock", 1'b1, lc_o);
      i_sta.access(1'b1, 5'h06, ADDR_BASIC_CTRL, 16'h1000, r, k);
      chk_out("foreign ack", 1'b0, k);
      rd(ADDR_BASIC_CTRL, 16'h2100);
      wr(ADDR_BASIC_CTRL, 16'h1000);
      chk_out("autoneg", 1'b1, an_o);
      for (int s = 0; s < 4; s++) begin
         sp = 2'(s);
         wr(ADDR_BASIC_CTRL, (16'(sp[0]) << 13) | (16'(sp[1]) << 6) | (16'(sp[0]) << 8));
         chk_out("autoneg", 1'b0, an_o);
         chk_reg("speed", {14'h0000, sp}, {14'h0000, spd_o});
         chk_out("duplex", sp[0], fd_o);
         chk_out("link", sp != SPD_RSVD, lnk_o);
      end
      wr(ADDR_BASIC_CTRL, 16'h0140);
      for (int i = 0; i < 8; i++) begin
         @(posedge i_clock);
         p_man <= i[1];
         p_mst <= i[0];
         wr(ADDR_GIG_CTRL, {3'h0, 1'b1, i[2], 11'h000});
         f = i[1] && (i[0] == i[2]);
         chk_out("fault", f, flt_o);
         chk_out("link", !f, lnk_o);
         rd(ADDR_GIG_STAT, {f, 15'h0000});
         if (!f) begin
            chk_out("master", i[2], ms_o);
            chk_out("local clock", i[2], lc_o);
         end
      end
      // station side: power down around expanded writes, then auto-increment, 16-bit and write-only access
      wr(ADDR_BASIC_CTRL, 16'h0940);
      chk_out("power down", 1'b1, pd_o);
      wr(ADDR_ACCESS_CTRL, 16'h0000);
      wr(ADDR_IND_PTR, 16'h01c0);
      wr(ADDR_IND_DATA, 16'h0008);
      wr(ADDR_BASIC_CTRL, 16'h0140);
      chk_out("power down", 1'b0, pd_o);
      rd(ADDR_IND_PTR, 16'h01c0);
      rd(ADDR_IND_DATA, 16'h0008);
      wr(ADDR_IND_DATA, 16'hab5c);
      rd(ADDR_IND_DATA, 16'h005c);
      wr(ADDR_ACCESS_CTRL, 16'h0002);
      wr(ADDR_IND_PTR, 16'h0010);
      wr(ADDR_IND_DATA, 16'h0011);
      wr(ADDR_IND_DATA, 16'h0022);
      rd(ADDR_IND_PTR, 16'h0012);
      wr(ADDR_IND_PTR, 16'h0010);
      rd(ADDR_IND_DATA, 16'h0011);
      rd(ADDR_IND_DATA, 16'h0022);
      rd(ADDR_IND_PTR, 16'h0012);
      wr(ADDR_ACCESS_CTRL, 16'h0003);
      wr(ADDR_IND_PTR, 16'h0020);
      wr(ADDR_IND_DATA, 16'hbeef);
      rd(ADDR_IND_PTR, 16'h0021);
      wr(ADDR_IND_PTR, 16'h0020);
      rd(ADDR_IND_DATA, 16'hbeef);
      wr(ADDR_ACCESS_CTRL, 16'h0007);
      wr(ADDR_IND_PTR, 16'h0020);
      rd(ADDR_IND_DATA, 16'h0000);
      rd(ADDR_IND_PTR, 16'h0021);
      rd(ADDR_ACCESS_CTRL, 16'h0007);
      wr(ADDR_IND_PTR, 16'hffff);
      rd(ADDR_IND_PTR, 16'hffff);
      wr(ADDR_PORT_ADDR, 16'h0005);
      rd(ADDR_PORT_ADDR, 16'h0005);
      tally_and_finish();
   end
endmodule : tb
